/* File: hw/slo_consts.svh */
// Constants of the shift and logic slice: register offsets, fields, resets.
// Assumes inclusion by bare name; holds definitions only.
`ifndef SLO_CONSTS_SVH
`define SLO_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SLO_OFS_WREG 12'h000
`define SLO_OFS_FLAGS 12'h004
`define SLO_OFS_PORT 12'h008
`define SLO_OFS_CMD 12'h00c
`define SLO_OFS_LAST 12'h010
`define SLO_OFS_COUNT 12'h014
`define SLO_OFS_MEM 12'h100

// ****************************************
// Command word fields
// ****************************************
`define SLO_CMD_OP_LSB 0
`define SLO_CMD_OP_MSB 3
`define SLO_CMD_DST_MEM 4
`define SLO_CMD_SRC_MEM 5
`define SLO_CMD_IDX_LSB 8
`define SLO_CMD_IMM_LSB 16

// ****************************************
// Flag bit positions and reset values
// ****************************************
`define SLO_FLAG_Z 0
`define SLO_FLAG_C 1
`define SLO_FLAG_AC 2
`define SLO_FLAG_OV 3
`define SLO_RST_BYTE 8'h00
`define SLO_RST_WORD 32'h0000_0000
`define SLO_MEM_DEPTH 16

`endif

/* File: hw/slo_pkg.sv */
// Types of the shift and logic slice.
// Assumes slo_consts.svh is compiled alongside.
package slo_pkg;

  // Operation selected by the command word
  typedef enum logic [3:0] {
    slo_op_shr_zero,
    slo_op_ror_carry,
    slo_op_shl_zero,
    slo_op_rol_carry,
    slo_op_swap,
    slo_op_and,
    slo_op_or,
    slo_op_xor,
    slo_op_not,
    slo_op_neg,
    slo_op_xor_io
  } slo_op_t;

  // Status flags, packed high to low
  typedef struct packed {
    logic ov;
    logic ac;
    logic c;
    logic z;
  } slo_flags_t;

endpackage : slo_pkg

/* File: hw/slo_alu_if.sv */
// Interface between the slice core and its operation unit.
// Assumes both ends run on the same clock; no timing lives here.
`timescale 1ns/1ps
interface slo_alu_if;
  import slo_pkg::*;
  slo_op_t op;
  logic [7:0] opa;
  logic [7:0] opb;
  logic cin;
  logic [7:0] res;
  logic cout;
  logic upd_z;
  logic upd_c;

  modport core (output op, output opa, output opb, output cin,
                input res, input cout, input upd_z, input upd_c);
  modport unit (input op, input opa, input opb, input cin,
                output res, output cout, output upd_z, output upd_c);
endinterface : slo_alu_if

/* File: hw/slo_alu.sv */
// Operation unit: combinational shift, rotate, swap and logic results.
// Assumes the core selects operands and commits results and flags.
`timescale 1ns/1ps
module slo_alu (
  // Operands and results
  slo_alu_if.unit u
);
  import slo_pkg::*;

  // ****************************************
  // Result and flag update selection
  // ****************************************
  always_comb begin
    u.res = u.opa;
    u.cout = u.cin;
    u.upd_z = 1'b0;
    u.upd_c = 1'b0;
    case (u.op)
      slo_op_shr_zero: begin
        u.res = {1'b0, u.opa[7:1]};
        u.cout = u.opa[0];
        u.upd_c = 1'b1;
      end
      slo_op_ror_carry: begin
        u.res = {u.cin, u.opa[7:1]};
        u.cout = u.opa[0];
        u.upd_c = 1'b1;
      end
      slo_op_shl_zero: begin
        u.res = {u.opa[6:0], 1'b0};
        u.cout = u.opa[7];
        u.upd_c = 1'b1;
      end
      slo_op_rol_carry: begin
        u.res = {u.opa[6:0], u.cin};
        u.cout = u.opa[7];
        u.upd_c = 1'b1;
      end
      slo_op_swap: begin
        u.res = {u.opa[3:0], u.opa[7:4]};
      end
      slo_op_and: begin
        u.res = u.opa & u.opb;
        u.upd_z = 1'b1;
      end
      slo_op_or: begin
        u.res = u.opa | u.opb;
        u.upd_z = 1'b1;
      end
      slo_op_xor: begin
        u.res = u.opa ^ u.opb;
        u.upd_z = 1'b1;
      end
      slo_op_not: begin
        u.res = ~u.opa;
        u.upd_z = 1'b1;
      end
      slo_op_neg: begin
        u.res = 8'(~u.opa + 8'h01);
        u.upd_z = 1'b1;
      end
      slo_op_xor_io: begin
        u.res = u.opa ^ u.opb;
      end
      default: begin
        u.res = u.opa;
      end
    endcase
  end

endmodule : slo_alu

/* File: hw/slo_top.sv */
// Shift and logic datapath slice with an APB register slave.
// Assumes an APB master on pclk; working register, flags, port byte and
// a small data memory live here and are written only through APB.
`timescale 1ns/1ps
`include "slo_consts.svh"

// Behaviour
// - Right shift fills zero, bit 0 to carry
// - Right rotate through carry into bit 7
// - Right shift and rotate on memory too
// - Left shift fills zero, bit 7 to carry
// - Left rotate through carry, register or memory
// - Shifts change only the carry flag
// - Swap exchanges nibbles, flags untouched
// - AND with immediate or memory byte
// - OR with immediate or memory byte
// - XOR with immediate or memory byte
// - XOR into port byte, flags untouched
// - One's complement of register or memory
// - Two's complement of register or memory
// - Logic ops update only zero flag
module slo_top #(
  parameter int MEM_DEPTH = `SLO_MEM_DEPTH
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Datapath state seen by the core
  output logic [7:0] working_register,
  output logic [7:0] first_port_data_register,
  output slo_pkg::slo_flags_t flags
);
  import slo_pkg::*;

  localparam int IDX_W = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [MEM_DEPTH-1:0][7:0] mem;
    logic [7:0] wreg;
    logic [7:0] port;
    slo_flags_t flg;
    logic [23:0] last_cmd;
    logic [7:0] last_res;
    logic [15:0] count;
    logic [31:0] rd_data;
    logic rd_err;
  } slo_state_t;

  slo_state_t cur;
  slo_state_t next_cur;

  slo_alu_if alu_bus ();

  // ****************************************
  // Operation unit
  // ****************************************
  slo_alu u_alu (
    .u (alu_bus.unit)
  );

  // ****************************************
  // Address decode and command fields
  // ****************************************
  logic setup;
  logic access;
  logic mem_hit;
  logic [IDX_W-1:0] mem_idx;
  logic reg_hit;
  logic [3:0] cmd_code;
  logic cmd_dst_mem;
  logic cmd_src_mem;
  logic [7:0] cmd_idx;
  logic [7:0] cmd_imm;
  logic [IDX_W-1:0] cmd_slot;
  logic cmd_slot_ok;
  logic cmd_legal;
  slo_op_t cmd_op;
  logic [7:0] mem_byte;

  // Per-register selects
  logic hit_wreg;
  logic hit_flags;
  logic hit_port;
  logic hit_cmd;
  logic hit_last;
  logic hit_count;

  // Read path and write strobes
  logic [31:0] rd_sel;
  logic rd_bad;
  logic wr_go;
  logic wr_mem;
  logic wr_wreg;
  logic wr_flags;
  logic wr_port;
  logic wr_cmd;

  // Command commit
  logic res_to_port;
  logic res_to_mem;
  logic res_to_wreg;
  slo_flags_t flg_after_cmd;

  // APB phases
  assign setup = psel & ~penable;
  assign access = psel & penable;

  // Memory window decode
  assign mem_idx = paddr[IDX_W+1:2];
  assign mem_hit = (paddr >= `SLO_OFS_MEM)
                   && (paddr < 12'(`SLO_OFS_MEM + 4 * MEM_DEPTH))
                   && (paddr[1:0] == 2'b00);

  // Register decode, one select per register
  always_comb begin
    hit_wreg = 1'b0;
    hit_flags = 1'b0;
    hit_port = 1'b0;
    hit_cmd = 1'b0;
    hit_last = 1'b0;
    hit_count = 1'b0;
    if (paddr == `SLO_OFS_WREG) begin
      hit_wreg = 1'b1;
    end else if (paddr == `SLO_OFS_FLAGS) begin
      hit_flags = 1'b1;
    end else if (paddr == `SLO_OFS_PORT) begin
      hit_port = 1'b1;
    end else if (paddr == `SLO_OFS_CMD) begin
      hit_cmd = 1'b1;
    end else if (paddr == `SLO_OFS_LAST) begin
      hit_last = 1'b1;
    end else if (paddr == `SLO_OFS_COUNT) begin
      hit_count = 1'b1;
    end
  end

  // Any register of the map
  assign reg_hit = hit_wreg | hit_flags | hit_port | hit_cmd | hit_last | hit_count;

  // Command word fields
  assign cmd_code = pwdata[`SLO_CMD_OP_MSB:`SLO_CMD_OP_LSB];
  assign cmd_dst_mem = pwdata[`SLO_CMD_DST_MEM];
  assign cmd_src_mem = pwdata[`SLO_CMD_SRC_MEM];
  assign cmd_idx = pwdata[`SLO_CMD_IDX_LSB +: 8];
  assign cmd_imm = pwdata[`SLO_CMD_IMM_LSB +: 8];
  assign cmd_slot = cmd_idx[IDX_W-1:0];
  assign cmd_slot_ok = (32'(cmd_idx) < 32'(MEM_DEPTH));
  assign cmd_op = slo_op_t'(cmd_code);
  assign mem_byte = cur.mem[cmd_slot];

  // Legal combinations of operation, source and destination
  always_comb begin
    cmd_legal = 1'b1;
    if (cmd_code > 4'(slo_op_xor_io)) begin
      cmd_legal = 1'b0;
    end else if ((cmd_dst_mem | cmd_src_mem) && !cmd_slot_ok) begin
      cmd_legal = 1'b0;
    end else if (cmd_op == slo_op_swap && cmd_dst_mem) begin
      // Swap works on the working register only
      cmd_legal = 1'b0;
    end else if (cmd_op == slo_op_xor_io && cmd_dst_mem) begin
      cmd_legal = 1'b0;
    end
  end

  // ****************************************
  // Operand selection
  // ****************************************
  always_comb begin
    alu_bus.op = cmd_op;
    alu_bus.cin = cur.flg.c;
    alu_bus.opa = cur.wreg;
    alu_bus.opb = cmd_src_mem ? mem_byte : cmd_imm;
    case (cmd_op)
      slo_op_shr_zero, slo_op_ror_carry, slo_op_shl_zero, slo_op_rol_carry,
      slo_op_not, slo_op_neg: begin
        alu_bus.opa = cmd_dst_mem ? mem_byte : cur.wreg;
      end
      slo_op_and, slo_op_or, slo_op_xor: begin
        // Memory destination combines the register with that byte
        alu_bus.opa = cur.wreg;
        alu_bus.opb = cmd_dst_mem ? mem_byte : alu_bus.opb;
      end
      slo_op_xor_io: begin
        alu_bus.opa = cur.wreg;
        alu_bus.opb = cur.port;
      end
      default: begin
        alu_bus.opa = cur.wreg;
      end
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_cur = cur;
    // Read data and error captured ahead of the access phase
    if (setup) begin
      next_cur.rd_data = rd_sel;
      next_cur.rd_err = rd_bad;
    end
    // Bus writes to the map
    if (wr_mem) begin
      next_cur.mem[mem_idx] = pwdata[7:0];
    end
    if (wr_wreg) begin
      next_cur.wreg = pwdata[7:0];
    end
    if (wr_flags) begin
      next_cur.flg = pwdata[3:0];
    end
    if (wr_port) begin
      next_cur.port = pwdata[7:0];
    end
    // Accepted command: record it and commit its result
    if (wr_cmd) begin
      next_cur.last_cmd = pwdata[23:0];
      next_cur.last_res = alu_bus.res;
      next_cur.count = cur.count + 16'h0001;
      next_cur.flg = flg_after_cmd;
      if (res_to_port) begin
        next_cur.port = alu_bus.res;
      end
      if (res_to_mem) begin
        next_cur.mem[cmd_slot] = alu_bus.res;
      end
      if (res_to_wreg) begin
        next_cur.wreg = alu_bus.res;
      end
    end
  end

  // ****************************************
  // Read data selection
  // ****************************************
  // Read word and error for the current address
  always_comb begin
    rd_sel = `SLO_RST_WORD;
    rd_bad = 1'b0;
    if (!mem_hit && !reg_hit) begin
      // Unmapped address answers with an error
      rd_bad = 1'b1;
    end else if (mem_hit) begin
      rd_sel = {24'h00_0000, cur.mem[mem_idx]};
    end else if (hit_wreg) begin
      rd_sel = {24'h00_0000, cur.wreg};
    end else if (hit_flags) begin
      rd_sel = {28'h000_0000, cur.flg};
    end else if (hit_port) begin
      rd_sel = {24'h00_0000, cur.port};
    end else if (hit_cmd) begin
      rd_sel = {8'h00, cur.last_cmd};
      // Refused command answers with an error
      rd_bad = pwrite & ~cmd_legal;
    end else if (hit_last) begin
      rd_sel = {24'h00_0000, cur.last_res};
    end else if (hit_count) begin
      rd_sel = {16'h0000, cur.count};
    end
  end

  // ****************************************
  // Write strobes
  // ****************************************
  // A write lands only at the access edge of an accepted transfer
  assign wr_go = access & pwrite & ~cur.rd_err;
  assign wr_mem = wr_go & mem_hit;
  assign wr_wreg = wr_go & hit_wreg;
  assign wr_flags = wr_go & hit_flags;
  assign wr_port = wr_go & hit_port;
  assign wr_cmd = wr_go & hit_cmd;

  // ****************************************
  // Command result routing
  // ****************************************
  // Result goes back where the operation names it
  always_comb begin
    res_to_port = 1'b0;
    res_to_mem = 1'b0;
    res_to_wreg = 1'b0;
    if (cmd_op == slo_op_xor_io) begin
      res_to_port = 1'b1;
    end else if (cmd_dst_mem) begin
      res_to_mem = 1'b1;
    end else begin
      res_to_wreg = 1'b1;
    end
  end

  // Flags after an accepted command
  always_comb begin
    flg_after_cmd = cur.flg;
    if (alu_bus.upd_c) begin
      flg_after_cmd.c = alu_bus.cout;
    end
    if (alu_bus.upd_z) begin
      flg_after_cmd.z = (alu_bus.res == 8'h00);
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Zero wait states: answer in the first access cycle
  assign pready = 1'b1;
  assign prdata = cur.rd_data;
  assign pslverr = access & cur.rd_err;
  assign working_register = cur.wreg;
  assign first_port_data_register = cur.port;
  assign flags = cur.flg;

endmodule : slo_top

/* File: dv/slo_top_props.sv */
// Checker of the slice: command writes against register and flag results.
// Assumes it is bound to slo_top and sees only its ports.
`timescale 1ns/1ps
`include "slo_consts.svh"
module slo_top_props #(
  parameter int MEM_DEPTH = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Datapath state
  input wire logic [7:0] working_register,
  input wire logic [7:0] first_port_data_register,
  input wire slo_pkg::slo_flags_t flags
);
  import slo_pkg::*;
  logic [7:0] pw;
  logic [7:0] pp;
  slo_flags_t pf;

  // Values held before the command edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pw <= 8'h00;
      pp <= 8'h00;
      pf <= 4'h0;
    end else begin
      pw <= working_register;
      pp <= first_port_data_register;
      pf <= flags;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************
  // Command sequences
  // ****************************************
  sequence s_acc;
    psel && penable && pwrite && paddr == `SLO_OFS_CMD && !pslverr;
  endsequence
  sequence s_cmd(logic [4:0] code);
    s_acc ##0 pwdata[4:0] == code;
  endsequence

  property p_shr;
    s_cmd(5'h00) |=> working_register == {1'b0, pw[7:1]} && flags.c == pw[0];
  endproperty
  a_shr: assert property (p_shr) else $error("right shift wrong");
  property p_ror;
    s_cmd(5'h01) |=> working_register == {pf.c, pw[7:1]} && flags.c == pw[0];
  endproperty
  a_ror: assert property (p_ror) else $error("right rotate wrong");
  property p_shl;
    s_cmd(5'h02) |=> working_register == {pw[6:0], 1'b0} && flags.c == pw[7];
  endproperty
  a_shl: assert property (p_shl) else $error("left shift wrong");
  property p_rol;
    s_cmd(5'h03) |=> working_register == {pw[6:0], pf.c} && flags.c == pw[7];
  endproperty
  a_rol: assert property (p_rol) else $error("left rotate wrong");
  property p_shflag;
    s_acc ##0 pwdata[3:0] < 4'h4 |=> {flags.ov, flags.ac, flags.z} == {pf.ov, pf.ac, pf.z};
  endproperty
  a_shflag: assert property (p_shflag) else $error("shift touched flags");
  property p_swap;
    s_cmd(5'h04) |=> working_register == {pw[3:0], pw[7:4]} && flags == pf;
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");
  property p_xio;
    s_cmd(5'h0a) |=> first_port_data_register == (pp ^ pw) && flags == pf;
  endproperty
  a_xio: assert property (p_xio) else $error("port xor wrong");
  property p_neg;
    s_cmd(5'h09) |=> working_register == 8'h00 - pw;
  endproperty
  a_neg: assert property (p_neg) else $error("negate wrong");
  property p_lflag;
    s_acc ##0 pwdata[3:0] inside {[4'h5:4'h9]} && !pwdata[4]
      |=> {flags.ov, flags.ac, flags.c} == {pf.ov, pf.ac, pf.c} && flags.z == (working_register == 0);
  endproperty
  a_lflag: assert property (p_lflag) else $error("logic flags wrong");
  property p_bad;
    psel && penable && pwrite && paddr == `SLO_OFS_CMD
      && (pwdata[3:0] > 4'ha || (pwdata[4] && pwdata[15:8] >= MEM_DEPTH)) |-> pslverr;
  endproperty
  a_bad: assert property (p_bad) else $error("bad command accepted");
endmodule : slo_top_props

/* File: dv/slo_core_model.sv */
// Model of the core side: an APB master issuing register and command cycles.
// Assumes a zero or longer wait slave on the same clock.
`timescale 1ns/1ps
module slo_core_model (
  // Clock
  input wire logic pclk,
  // APB master
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
  end

  // One transfer, held until pready is seen
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : slo_core_model

/* File: dv/tb.sv */
// Testbench of the slice: commands over APB, results judged at the ports.
// Assumes the core model drives the bus; the checker is bound at the foot.
`timescale 1ns/1ps
`include "slo_consts.svh"
`define CHK(a, x) begin checks++; if ((a) !== (x)) begin bad_count++; \
  $display("CHECK FAILED %0t got %h want %h", $time, a, x); end end
module tb;
  import slo_pkg::*;
  localparam int MEM_DEPTH = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] working_register, first_port_data_register;
  slo_flags_t flags;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;

  always #50 pclk = ~pclk;

  slo_top #(.MEM_DEPTH(MEM_DEPTH)) slo_top_inst (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .working_register,
    .first_port_data_register, .flags);
  slo_core_model bus (.pclk, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr);

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    bus.xfer(1'b0, a, 32'h0, q, e);
  endtask : rd
  // Command {src, dst, op}, then let results settle
  task automatic cmd(input logic [5:0] c, input logic [7:0] idx, input logic [7:0] imm);
    bus.xfer(1'b1, `SLO_OFS_CMD, {8'h00, imm, idx, 2'b00, c}, q, e);
    @(negedge pclk);
  endtask : cmd
  task automatic put(input logic [7:0] w, input logic [3:0] f);
    wr(`SLO_OFS_WREG, {24'h0, w});
    wr(`SLO_OFS_FLAGS, {28'h0, f});
  endtask : put

  task automatic t_reset();
    `CHK({working_register, first_port_data_register, flags}, 20'h0)
    `CHK({pready, pslverr, prdata}, {2'b10, 32'h0})
    rd(12'h0f0);
    `CHK({e, q}, 33'h1_0000_0000)
    $display("reset test done");
  endtask : t_reset

  // Shifts and rotates, register and memory, carry in 0 and 1
  task automatic t_shift();
    logic [8:0] x;
    logic [7:0] v;
    for (int k = 0; k < 16; k++) begin
      v = k[3] ? 8'h5a : 8'h81;
      case (k[2:1])
        2'd0: x = {v[0], 1'b0, v[7:1]};
        2'd1: x = {v[0], k[0], v[7:1]};
        2'd2: x = {v[7], v[6:0], 1'b0};
        default: x = {v[7], v[6:0], k[0]};
      endcase
      wr(`SLO_OFS_MEM + 12'h008, 32'h5a);
      put(8'h81, {2'b11, k[0], 1'b1});
      cmd({1'b0, k[3], 2'b00, k[2:1]}, 8'h02, 8'h00);
      rd(`SLO_OFS_MEM + 12'h008);
      `CHK(k[3] ? q[7:0] : working_register, x[7:0])
      `CHK(flags, {2'b11, x[8], 1'b1})
    end
    cmd(6'h10, MEM_DEPTH[7:0], 8'h00);
    `CHK(e, 1'b1)
    $display("shift test done");
  endtask : t_shift

  task automatic t_swap();
    put(8'h3c, 4'ha);
    cmd(6'h04, 8'h00, 8'h00);
    `CHK({working_register, flags}, {8'hc3, 4'ha})
    $display("swap test done");
  endtask : t_swap

  // AND, OR, XOR with immediate, memory source and memory destination
  task automatic t_logic();
    logic [7:0] b, r;
    for (int k = 0; k < 9; k++) begin
      b = (k % 3 == 0) ? 8'h0f : 8'h3c;
      r = k < 3 ? 8'hf0 & b : k < 6 ? 8'hf0 | b : 8'hf0 ^ b;
      wr(`SLO_OFS_MEM + 12'h004, 32'h3c);
      put(8'hf0, 4'he);
      cmd({k % 3 == 1, k % 3 == 2, 4'(5 + k / 3)}, 8'h01, 8'h0f);
      rd(`SLO_OFS_MEM + 12'h004);
      `CHK(k % 3 == 2 ? q[7:0] : working_register, r)
      `CHK(flags, {3'b111, r == 8'h00})
    end
    $display("logic test done");
  endtask : t_logic

  // Complement and negate, zero result included
  task automatic t_not_neg();
    logic [7:0] v, x;
    logic [3:0] op;
    for (int k = 0; k < 4; k++) begin
      v = k == 2 ? 8'h00 : 8'h38;
      op = (k == 1 || k == 2) ? 4'h9 : 4'h8;
      x = op == 4'h9 ? 8'h00 - v : ~v;
      wr(`SLO_OFS_MEM, {24'h0, v});
      put(v, 4'he);
      cmd({1'b0, k == 3, op}, 8'h00, 8'h00);
      rd(`SLO_OFS_MEM);
      `CHK(k == 3 ? q[7:0] : working_register, x)
      `CHK(flags, {3'b111, x == 8'h00})
    end
    $display("complement test done");
  endtask : t_not_neg

  task automatic t_port();
    wr(`SLO_OFS_PORT, 32'h55);
    put(8'h0f, 4'h5);
    cmd(6'h0a, 8'h00, 8'h00);
    `CHK({first_port_data_register, flags}, {8'h5a, 4'h5})
    cmd(6'h0b, 8'h00, 8'h00);
    `CHK({e, working_register}, {1'b1, 8'h0f})
    cmd(6'h14, 8'h00, 8'h00);
    `CHK({e, working_register}, {1'b1, 8'h0f})
    cmd(6'h1a, 8'h00, 8'h00);
    `CHK({e, first_port_data_register}, {1'b1, 8'h5a})
    // Last result, accepted command count and last command word
    rd(`SLO_OFS_LAST);
    `CHK({e, q}, {1'b0, 32'h5a})
    rd(`SLO_OFS_COUNT);
    `CHK({e, q}, {1'b0, 32'h1f})
    rd(`SLO_OFS_CMD);
    `CHK({e, q}, {1'b0, 32'h0a})
    $display("port test done");
  endtask : t_port

  // Reset in mid-run clears registers and memory
  task automatic t_reset_mid();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK({working_register, first_port_data_register, flags, pslverr, prdata}, 53'h0)
    presetn <= 1'b1;
    rd(`SLO_OFS_MEM);
    `CHK({e, q}, 33'h0)
    rd(`SLO_OFS_COUNT);
    `CHK({e, q}, 33'h0)
    $display("mid-run reset test done");
  endtask : t_reset_mid

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_shift();
    t_swap();
    t_logic();
    t_not_neg();
    t_port();
    t_reset_mid();
    wrap_up();
  end
endmodule : tb

bind slo_top slo_top_props #(.MEM_DEPTH(MEM_DEPTH)) props_inst (.pclk, .presetn, .paddr,
  .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .working_register,
  .first_port_data_register, .flags);
